// [core/modem_status_pkg.sv]
/*
  Constants for the modem status monitor: bit positions, routing,
  reset values, timing counts.
  Assumes a 125 MHz system clock.
*/
package modem_status_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RING_QUALIFY_NS = 10_000_000;
  localparam int RING_QUALIFY_CYCLES = RING_QUALIFY_NS / CLK_PERIOD_NS;
  localparam int MAINT_CLOCK_HALF_NS = 50_000;
  localparam int MAINT_HALF_CYCLES = MAINT_CLOCK_HALF_NS / CLK_PERIOD_NS;
  localparam int RING_COUNT_W = 21;
  localparam int MAINT_COUNT_W = 13;

  // ----------------------------------------------------------------------
  // Monitored line indices
  // ----------------------------------------------------------------------
  localparam int LINE_COUNT = 6;
  localparam int LINE_READY = 0;
  localparam int LINE_SECONDARY_RECEIVE_LEVEL = 1;
  localparam int LINE_CARRIER = 2;
  localparam int LINE_CTS = 3;
  localparam int LINE_RING = 4;
  localparam int LINE_TX_CLOCK = 5;

  // ----------------------------------------------------------------------
  // Receiver control/status register bit positions
  // ----------------------------------------------------------------------
  localparam int CSR_W = 16;
  localparam int BIT_FLAG_B = 0;
  localparam int BIT_TERMINAL_READY = 1;
  localparam int BIT_REQUEST_SEND = 2;
  localparam int BIT_SEC_TRANSMIT = 3;
  localparam int BIT_IRQ_ENABLE = 5;
  localparam int BIT_READY_LEVEL = 9;
  localparam int BIT_SECONDARY_RECEIVE_LEVEL_LEVEL = 10;
  localparam int BIT_CARRIER_LEVEL = 12;
  localparam int BIT_CTS_LEVEL = 13;
  localparam int BIT_RING_LEVEL = 14;
  localparam int BIT_FLAG_A = 15;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODEM_CTRL_RESET = 3'h0;
  localparam logic [CSR_W-1:0] CSR_READ_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Flag routing options
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ROUTE_STANDARD = 2'h0,
    ROUTE_ALL_TO_A = 2'h1,
    ROUTE_B_MONITOR = 2'h2
  } flag_route_e;

endpackage

// [core/modem_lines_if.sv]
/*
  Carrier for synchronised modem line levels and their edge events.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
interface modem_lines_if;
  import modem_status_pkg::*;
  logic [LINE_COUNT-1:0] level;
  logic [LINE_COUNT-1:0] rise;
  logic [LINE_COUNT-1:0] fall;
  modport detect (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface

// [core/modem_line_detect.sv]
/*
  Two-stage synchroniser and edge detector for each modem line.
  Assumes lines are asynchronous to clk_i; rise and fall outputs are one-cycle events.
*/
`timescale 1ns/100ps
module modem_line_detect
  import modem_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Lines
  input wire logic [LINE_COUNT-1:0] lines_i,
  modem_lines_if.detect lines_o
);

  logic [LINE_COUNT-1:0] meta_reg, meta_next;
  logic [LINE_COUNT-1:0] sync_reg, sync_next;
  logic [LINE_COUNT-1:0] level_reg, level_next;
  logic [LINE_COUNT-1:0] rise_reg, rise_next;
  logic [LINE_COUNT-1:0] fall_reg, fall_next;

  // ----------------------------------------------------------------------
  // Per-line edge compare
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LINE_COUNT; g++) begin : g_line
      assign rise_next[g] = ce_i ? (sync_reg[g] & ~level_reg[g]) : rise_reg[g];
      assign fall_next[g] = ce_i ? (~sync_reg[g] & level_reg[g]) : fall_reg[g];
    end
  endgenerate

  always_comb begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    level_next = level_reg;
    if (ce_i) begin
      meta_next = lines_i;
      sync_next = meta_reg;
      level_next = sync_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      level_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      level_reg <= level_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign lines_o.level = level_reg;
  assign lines_o.rise = rise_reg;
  assign lines_o.fall = fall_reg;

endmodule // modem_line_detect

// [core/receive_link_capture.sv]
/*
  Samples received serial data on the modem receive clock and hands each
  bit to the system clock by a toggle crossing.
  Assumes one bit period spans at least three system clock cycles.
*/
`timescale 1ns/100ps
module receive_link_capture
  import modem_status_pkg::*;
(
  // System side
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  output logic rx_bit_tick_o,
  output logic rx_bit_o,
  // Link side
  input wire logic modem_receive_clock_i,
  input wire logic rx_serial_data_i
);

  logic link_bit_reg, link_bit_next;
  logic link_toggle_reg, link_toggle_next;
  logic tog_meta_reg, tog_sync_reg, tog_prev_reg;
  logic tog_meta_next, tog_sync_next, tog_prev_next;
  logic tick_reg, tick_next;
  logic bit_reg, bit_next;

  // ----------------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------------
  always_comb begin
    link_bit_next = rx_serial_data_i;
    link_toggle_next = ~link_toggle_reg;
  end

  always_ff @(posedge modem_receive_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_bit_reg <= 1'b0;
      link_toggle_reg <= 1'b0;
    end else begin
      link_bit_reg <= link_bit_next;
      link_toggle_reg <= link_toggle_next;
    end
  end

  // ----------------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------------
  always_comb begin
    tog_meta_next = tog_meta_reg;
    tog_sync_next = tog_sync_reg;
    tog_prev_next = tog_prev_reg;
    tick_next = tick_reg;
    bit_next = bit_reg;
    if (ce_i) begin
      tog_meta_next = link_toggle_reg;
      tog_sync_next = tog_meta_reg;
      tog_prev_next = tog_sync_reg;
      tick_next = tog_sync_reg ^ tog_prev_reg;
      if (tog_sync_reg ^ tog_prev_reg) begin
        bit_next = link_bit_reg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_prev_reg <= 1'b0;
      tick_reg <= 1'b0;
      bit_reg <= 1'b0;
    end else begin
      tog_meta_reg <= tog_meta_next;
      tog_sync_reg <= tog_sync_next;
      tog_prev_reg <= tog_prev_next;
      tick_reg <= tick_next;
      bit_reg <= bit_next;
    end
  end

  assign rx_bit_tick_o = tick_reg;
  assign rx_bit_o = bit_reg;

endmodule // receive_link_capture

// [core/modem_status_change_monitor.sv]
/*
  Modem status change monitor: level bits, change flags A and B, modem
  control outputs, receive/transmit clock forwarding and transmit gating.
  Assumes the read strobe and load strobe come from logic on clk_i.
*/
// Contract
// - Seven modem status and flag bits appear at 0, 9, 10, 12-15.
// - Register bits 1, 2, 3 drive three control outputs to the modem.
// - Modem receive clock is the receiver's bit timing source.
// - Modem transmit clock is polarity corrected and times the transmitter.
// - Received serial data goes in true polarity to the receiver.
// - Ready, secondary receive, carrier, clear to send levels at 9, 10, 12, 13.
// - Every rise and fall on those four lines yields an event pulse.
// - Flag B sets on secondary receive, ready or carrier transitions in standard routing only.
// - Flag B is read-only, cleared at the trailing edge of a read.
// - Flag A sets on any clear-to-send transition.
// - Flag A also sets on qualified ring transitions; read-only.
// - With enable bit 5 set, flag A raises a receiver interrupt.
// - Reading the register clears flag A.
// - Standard routing: ring and CTS to A, others to B.
// - Compatibility routing: all five lines set A; B never sets.
// - Monitor routing: group-B lines set no flag, only levels.
// - Gate transmit data in user mode, maintenance clock in maintenance mode.
// - Ring level is bit 14; its transitions set flag A.
// - Rising ring sets A after 10 ms qualification; falling sets at once.
// - Control bits load on low-byte write; reset clears them unless configured.
`timescale 1ns/100ps
module modem_status_change_monitor
  import modem_status_pkg::*;
#(
  parameter flag_route_e FLAG_ROUTE = ROUTE_STANDARD,
  parameter bit CTRL_CLEAR_ON_RESET = 1'b1,
  parameter int RING_CYCLES = RING_QUALIFY_CYCLES,
  parameter int MAINT_CYCLES = MAINT_HALF_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Register access
  input wire logic status_read_strobe_n_i,
  input wire logic status_low_byte_load_i,
  input wire logic [7:0] write_data_i,
  output logic [CSR_W-1:0] receiver_control_status_o,
  output logic rx_irq_request_o,
  // Modem status lines
  input wire logic modem_ready_i,
  input wire logic secondary_receive_i,
  input wire logic carrier_detect_i,
  input wire logic clear_to_send_i,
  input wire logic ring_indicator_i,
  input wire logic modem_transmit_clock_n_i,
  input wire logic modem_receive_clock_i,
  input wire logic rx_serial_data_i,
  // Modem control lines
  output logic terminal_ready_o,
  output logic request_to_send_o,
  output logic secondary_transmit_out_o,
  output logic tx_line_data_o,
  // Receiver and transmitter side
  input wire logic tx_serial_data_i,
  input wire logic tx_data_enable_i,
  input wire logic external_maint_mode_i,
  output logic modem_transmit_clock_o,
  output logic tx_bit_tick_o,
  output logic rx_bit_tick_o,
  output logic rx_bit_o
);

  modem_lines_if lines ();

  logic [LINE_COUNT-1:0] line_pins;
  logic flag_a_reg, flag_a_next;
  logic flag_b_reg, flag_b_next;
  logic irq_en_reg, irq_en_next;
  logic irq_reg, irq_next;
  logic read_n_prev_reg, read_n_prev_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [RING_COUNT_W-1:0] ring_cnt_reg, ring_cnt_next;
  logic ring_busy_reg, ring_busy_next;
  logic [MAINT_COUNT_W-1:0] maint_cnt_reg, maint_cnt_next;
  logic maint_clk_reg, maint_clk_next;
  logic tx_line_reg, tx_line_next;
  logic tx_clk_reg, tx_clk_next;
  logic tx_tick_reg, tx_tick_next;
  logic [CSR_W-1:0] csr_reg, csr_next;
  logic read_done;
  logic group_b_event;
  logic cts_event;
  logic ring_event;
  logic set_a;
  logic set_b;

  // ----------------------------------------------------------------------
  // Line synchronisers and receive link
  // ----------------------------------------------------------------------
  always_comb begin
    line_pins = '0;
    line_pins[LINE_READY] = modem_ready_i;
    line_pins[LINE_SECONDARY_RECEIVE_LEVEL] = secondary_receive_i;
    line_pins[LINE_CARRIER] = carrier_detect_i;
    line_pins[LINE_CTS] = clear_to_send_i;
    line_pins[LINE_RING] = ring_indicator_i;
    line_pins[LINE_TX_CLOCK] = ~modem_transmit_clock_n_i;
  end

  modem_line_detect u_detect (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .lines_i(line_pins),
    .lines_o(lines.detect)
  );

  receive_link_capture u_rx_link (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .rx_bit_tick_o(rx_bit_tick_o),
    .rx_bit_o(rx_bit_o),
    .modem_receive_clock_i(modem_receive_clock_i),
    .rx_serial_data_i(rx_serial_data_i)
  );

  // ----------------------------------------------------------------------
  // Event routing
  // ----------------------------------------------------------------------
  always_comb begin
    group_b_event = |(lines.rise[LINE_CARRIER:LINE_READY]
                      | lines.fall[LINE_CARRIER:LINE_READY]);
    cts_event = lines.rise[LINE_CTS] | lines.fall[LINE_CTS];
    ring_event = lines.fall[LINE_RING]
                 | (ring_busy_reg && ring_cnt_reg == RING_COUNT_W'(1));
    read_done = ~read_n_prev_reg & status_read_strobe_n_i;
    set_a = cts_event | ring_event;
    set_b = 1'b0;
    unique case (FLAG_ROUTE)
      ROUTE_STANDARD: set_b = group_b_event;
      ROUTE_ALL_TO_A: set_a = cts_event | ring_event | group_b_event;
      ROUTE_B_MONITOR: set_b = 1'b0;
      default: set_b = group_b_event;
    endcase
  end

  // ----------------------------------------------------------------------
  // Flags, ring qualification, interrupt
  // ----------------------------------------------------------------------
  always_comb begin
    flag_a_next = flag_a_reg;
    flag_b_next = flag_b_reg;
    irq_next = irq_reg;
    read_n_prev_next = read_n_prev_reg;
    ring_cnt_next = ring_cnt_reg;
    ring_busy_next = ring_busy_reg;
    irq_en_next = irq_en_reg;
    if (ce_i) begin
      read_n_prev_next = status_read_strobe_n_i;
      flag_a_next = (flag_a_reg & ~read_done) | set_a;
      flag_b_next = (flag_b_reg & ~read_done) | set_b;
      if (status_low_byte_load_i) begin
        irq_en_next = write_data_i[BIT_IRQ_ENABLE];
      end
      irq_next = flag_a_next & irq_en_next;
      if (lines.rise[LINE_RING]) begin
        ring_busy_next = 1'b1;
        ring_cnt_next = RING_COUNT_W'(RING_CYCLES);
      end else if (lines.fall[LINE_RING] || !lines.level[LINE_RING]) begin
        ring_busy_next = 1'b0;
      end else if (ring_busy_reg) begin
        ring_cnt_next = ring_cnt_reg - RING_COUNT_W'(1);
        if (ring_cnt_reg == RING_COUNT_W'(1)) begin
          ring_busy_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
      irq_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      read_n_prev_reg <= 1'b1;
      ring_cnt_reg <= '0;
      ring_busy_reg <= 1'b0;
    end else begin
      flag_a_reg <= flag_a_next;
      flag_b_reg <= flag_b_next;
      irq_reg <= irq_next;
      irq_en_reg <= irq_en_next;
      read_n_prev_reg <= read_n_prev_next;
      ring_cnt_reg <= ring_cnt_next;
      ring_busy_reg <= ring_busy_next;
    end
  end

  // ----------------------------------------------------------------------
  // Modem control bits
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ce_i && status_low_byte_load_i) begin
      ctrl_next = write_data_i[BIT_SEC_TRANSMIT:BIT_TERMINAL_READY];
    end
  end

  generate
    if (CTRL_CLEAR_ON_RESET) begin : g_ctrl_reset
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ctrl_reg <= MODEM_CTRL_RESET;
        end else begin
          ctrl_reg <= ctrl_next;
        end
      end
    end else begin : g_ctrl_soft
      always_ff @(posedge clk_i) begin
        ctrl_reg <= ctrl_next;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Transmit clock, maintenance clock, transmit line
  // ----------------------------------------------------------------------
  always_comb begin
    maint_cnt_next = maint_cnt_reg;
    maint_clk_next = maint_clk_reg;
    tx_line_next = tx_line_reg;
    tx_clk_next = tx_clk_reg;
    tx_tick_next = tx_tick_reg;
    if (ce_i) begin
      if (maint_cnt_reg == MAINT_COUNT_W'(MAINT_CYCLES - 1)) begin
        maint_cnt_next = '0;
        maint_clk_next = ~maint_clk_reg;
      end else begin
        maint_cnt_next = maint_cnt_reg + MAINT_COUNT_W'(1);
      end
      tx_clk_next = lines.level[LINE_TX_CLOCK];
      tx_tick_next = lines.rise[LINE_TX_CLOCK];
      tx_line_next = external_maint_mode_i ? maint_clk_reg
                     : (tx_serial_data_i & tx_data_enable_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      maint_cnt_reg <= '0;
      maint_clk_reg <= 1'b0;
      tx_line_reg <= 1'b0;
      tx_clk_reg <= 1'b0;
      tx_tick_reg <= 1'b0;
    end else begin
      maint_cnt_reg <= maint_cnt_next;
      maint_clk_reg <= maint_clk_next;
      tx_line_reg <= tx_line_next;
      tx_clk_reg <= tx_clk_next;
      tx_tick_reg <= tx_tick_next;
    end
  end

  // ----------------------------------------------------------------------
  // Register read image
  // ----------------------------------------------------------------------
  always_comb begin
    csr_next = csr_reg;
    if (ce_i) begin
      csr_next = CSR_READ_RESET;
      csr_next[BIT_FLAG_B] = flag_b_reg;
      csr_next[BIT_SEC_TRANSMIT:BIT_TERMINAL_READY] = ctrl_reg;
      csr_next[BIT_IRQ_ENABLE] = irq_en_reg;
      csr_next[BIT_READY_LEVEL] = lines.level[LINE_READY];
      csr_next[BIT_SECONDARY_RECEIVE_LEVEL_LEVEL] = lines.level[LINE_SECONDARY_RECEIVE_LEVEL];
      csr_next[BIT_CARRIER_LEVEL] = lines.level[LINE_CARRIER];
      csr_next[BIT_CTS_LEVEL] = lines.level[LINE_CTS];
      csr_next[BIT_RING_LEVEL] = lines.level[LINE_RING];
      csr_next[BIT_FLAG_A] = flag_a_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      csr_reg <= CSR_READ_RESET;
    end else begin
      csr_reg <= csr_next;
    end
  end

  assign receiver_control_status_o = csr_reg;
  assign rx_irq_request_o = irq_reg;
  assign terminal_ready_o = ctrl_reg[0];
  assign request_to_send_o = ctrl_reg[1];
  assign secondary_transmit_out_o = ctrl_reg[2];
  assign tx_line_data_o = tx_line_reg;
  assign modem_transmit_clock_o = tx_clk_reg;
  assign tx_bit_tick_o = tx_tick_reg;

endmodule // modem_status_change_monitor

// [tb/modem_status_assertions.sv]
/*
  Port checker for the modem status monitor.
  Assumes inputs on clk_i, ce_i high.
*/
`timescale 1ns/100ps
module modem_status_assertions
  import modem_status_pkg::*;
#(
  parameter flag_route_e FLAG_ROUTE = ROUTE_STANDARD,
  parameter int RING_CYCLES = RING_QUALIFY_CYCLES,
  parameter int MAINT_CYCLES = MAINT_HALF_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Register access
  input wire logic status_read_strobe_n_i,
  input wire logic status_low_byte_load_i,
  input wire logic [7:0] write_data_i,
  input wire logic [CSR_W-1:0] receiver_control_status_o,
  input wire logic rx_irq_request_o,
  // Modem lines
  input wire logic modem_ready_i,
  input wire logic secondary_receive_i,
  input wire logic carrier_detect_i,
  input wire logic clear_to_send_i,
  input wire logic ring_indicator_i,
  input wire logic terminal_ready_o,
  input wire logic request_to_send_o,
  input wire logic secondary_transmit_out_o,
  // Transmit path
  input wire logic tx_line_data_o,
  input wire logic tx_serial_data_i,
  input wire logic tx_data_enable_i,
  input wire logic external_maint_mode_i
);
  // --------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------
  logic [CSR_W-1:0] csr;
  logic [4:0] pins, pins_reg;
  logic [2:0] ctrl_out;
  int quiet_reg;
  assign csr = receiver_control_status_o;
  assign pins = {ring_indicator_i, clear_to_send_i, carrier_detect_i, secondary_receive_i,
                 modem_ready_i};
  assign ctrl_out = {secondary_transmit_out_o, request_to_send_o, terminal_ready_o};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_reg <= 5'h00;
      quiet_reg <= 0;
    end else begin
      pins_reg <= pins;
      if (pins != pins_reg) quiet_reg <= 0;
      else if (quiet_reg < 1000) quiet_reg <= quiet_reg + 1;
    end
  end
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  cts_flag_a:
    assert property ($changed(clear_to_send_i) |-> ##[3:8] csr[BIT_FLAG_A])
      else $error("flag A missed CTS change");
  ready_flag_b_a:
    assert property (FLAG_ROUTE == ROUTE_STANDARD && $changed(modem_ready_i)
      |-> ##[3:8] csr[BIT_FLAG_B]) else $error("flag B missed a ready change");
  irq_cause_a:
    assert property (rx_irq_request_o |=> csr[BIT_FLAG_A] && csr[BIT_IRQ_ENABLE])
      else $error("irq without cause");
  ctrl_load_a:
    assert property (status_low_byte_load_i && ce_i |=> ctrl_out == $past(write_data_i[3:1]))
      else $error("control outputs not loaded");
  ctrl_image_a:
    assert property (csr[3:1] == $past(ctrl_out))
      else $error("control image wrong");
  spare_zero_a:
    assert property (csr[4] == 1'b0 && csr[8:6] == 3'h0 && csr[11] == 1'b0)
      else $error("spare bits set");
  level_bits_a:
    assert property ($changed(pins) ##1 $stable(pins) [*8] |-> {csr[14:12], csr[10:9]} == pins)
      else $error("level bits wrong");
  read_hold_a:
    assert property (status_read_strobe_n_i [*3] ##1 !status_read_strobe_n_i && csr[BIT_FLAG_A]
      |=> csr[BIT_FLAG_A]) else $error("flag A lost early");
  read_clear_a:
    assert property ($rose(status_read_strobe_n_i) && quiet_reg > RING_CYCLES + 8
      |-> ##3 !csr[BIT_FLAG_A] && !csr[BIT_FLAG_B]) else $error("flags not cleared by read");
  tx_gate_a:
    assert property (!external_maint_mode_i |=> tx_line_data_o ==
      ($past(tx_serial_data_i) && $past(tx_data_enable_i))) else $error("transmit data not gated");
  maint_clock_a:
    assert property (MAINT_CYCLES <= 4 && external_maint_mode_i ##1 external_maint_mode_i
      |-> ##[1:9] $changed(tx_line_data_o)) else $error("no maintenance clock");
endmodule // modem_status_assertions

// [tb/modem_model.sv]
/*
  Behavioural modem: status lines, clocks, receive data.
  Assumes bench commands.
*/
`timescale 1ns/100ps
module modem_model (
  // Commands
  input wire logic [4:0] lines_i,
  input wire logic rx_frame_i,
  input wire logic rx_value_i,
  input wire logic tx_run_i,
  // Pins
  output logic [4:0] status_o,
  output logic receive_clock_o,
  output logic rx_data_o,
  output logic transmit_clock_n_o
);
  // --------------------------------------------------------------
  // Line behaviour
  // --------------------------------------------------------------
  assign status_o = lines_i;
  // Idle data is the inverse
  assign rx_data_o = rx_frame_i ? rx_value_i : ~rx_value_i;
  // 6 ns receive clock, frames only
  initial begin
    receive_clock_o = 1'b0;
    #1.7;
    forever begin
      #3;
      receive_clock_o = rx_frame_i ? ~receive_clock_o : 1'b0;
    end
  end
  // Inverted transmit clock idles high
  initial begin
    transmit_clock_n_o = 1'b1;
    forever begin
      #40;
      transmit_clock_n_o = tx_run_i ? ~transmit_clock_n_o : 1'b1;
    end
  end
endmodule // modem_model

// [tb/tb_top.sv]
/*
  Bench for the modem status monitor.
  Assumes the modem model and bound checker.
*/
`timescale 1ns/100ps
module tb_top;
  import modem_status_pkg::*;
  // --------------------------------------------------------------
  // Signals and stimulus table
  // --------------------------------------------------------------
  localparam int RING_CYC = 20;
  typedef struct packed {
    logic [7:0] wd;
    logic [4:0] lines;
    logic [15:0] img;
  } row_s;
  row_s rows [6] = '{'{8'h2E, 5'h00, 16'h002E}, '{8'h02, 5'h01, 16'h0203},
                     '{8'h24, 5'h09, 16'hA224}, '{8'h08, 5'h0E, 16'h3409},
                     '{8'h20, 5'h1E, 16'hF420}, '{8'h00, 5'h00, 16'h8001}};
  logic clk_i = 1'b0;
  logic rst_b_i, rd_n, ld, txd, txe, maint, frame, rxv, txrun, b;
  logic [7:0] wd;
  logic [4:0] lines, st;
  logic rx_clk, rx_dat, txc_n, irq, term_rdy, rts, stx, tx_line, txc, tx_tick, rx_tick, rx_bit;
  logic [15:0] csr, v;
  int fails = 0, total_checks = 0, cycles = 0, tx_edges = 0, tx_ticks = 0, rx_ticks = 0, n;
  modem_model modem (.lines_i(lines), .rx_frame_i(frame), .rx_value_i(rxv), .tx_run_i(txrun),
    .status_o(st), .receive_clock_o(rx_clk), .rx_data_o(rx_dat), .transmit_clock_n_o(txc_n));
  modem_status_change_monitor #(.RING_CYCLES(RING_CYC), .MAINT_CYCLES(4)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .status_read_strobe_n_i(rd_n), .status_low_byte_load_i(ld), .write_data_i(wd),
    .receiver_control_status_o(csr), .rx_irq_request_o(irq),
    .modem_ready_i(st[0]), .secondary_receive_i(st[1]), .carrier_detect_i(st[2]),
    .clear_to_send_i(st[3]), .ring_indicator_i(st[4]), .modem_transmit_clock_n_i(txc_n),
    .modem_receive_clock_i(rx_clk), .rx_serial_data_i(rx_dat),
    .terminal_ready_o(term_rdy), .request_to_send_o(rts), .secondary_transmit_out_o(stx),
    .tx_line_data_o(tx_line), .tx_serial_data_i(txd), .tx_data_enable_i(txe),
    .external_maint_mode_i(maint), .modem_transmit_clock_o(txc), .tx_bit_tick_o(tx_tick),
    .rx_bit_tick_o(rx_tick), .rx_bit_o(rx_bit));
  always #4 clk_i = ~clk_i;
  always @(negedge txc_n) tx_edges++;
  always @(posedge clk_i) begin
    if (tx_tick === 1'b1) tx_ticks++;
    if (rx_tick === 1'b1) rx_ticks++;
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic write_ctrl(input logic [7:0] d);
    wd = d;
    ld = 1'b1;
    wait_cyc(1);
    ld = 1'b0;
  endtask
  task automatic read_csr(output logic [15:0] r);
    rd_n = 1'b0;
    wait_cyc(1);
    r = csr;
    rd_n = 1'b1;
    wait_cyc(4);
  endtask
  task automatic check_reset();
    check("reset image", CSR_READ_RESET, csr);
    check("reset outputs", 16'h0, {12'h0, irq, term_rdy, rts, stx});
  endtask
  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    {rst_b_i, ld, txd, txe, maint, frame, rxv, txrun, wd, lines} = '0;
    rd_n = 1'b1;
    wait_cyc(7);
    check_reset();
    wait_cyc(1);
    rst_b_i = 1'b1;
    foreach (rows[i]) begin
      lines = rows[i].lines;
      write_ctrl(rows[i].wd);
      wait_cyc(40);
      check("image", rows[i].img, csr);
      check("irq", {15'h0, rows[i].img[15] & rows[i].img[5]}, {15'h0, irq});
      check("controls", {13'h0, rows[i].img[3:1]}, {13'h0, stx, rts, term_rdy});
      read_csr(v);
      check("read value", rows[i].img, v);
      check("cleared", rows[i].img & 16'h7FFE, csr);
    end
    lines = 5'h10;
    wait_cyc(12);
    check("ring pending", 16'h4000, csr);
    wait_cyc(30);
    check("ring qualified", 16'hC000, csr);
    read_csr(v);
    lines = 5'h00;
    wait_cyc(8);
    check("ring fall", 16'h8000, csr);
    read_csr(v);
    write_ctrl(8'h2E);
    lines = 5'h08;
    wait_cyc(20);
    check("irq set", 16'h1, {15'h0, irq});
    rst_b_i = 1'b0;
    lines = 5'h00;
    wait_cyc(2);
    check_reset();
    rst_b_i = 1'b1;
    wait_cyc(10);
    txd = 1'b1;
    txe = 1'b1;
    wait_cyc(2);
    check("tx data on", 16'h1, {15'h0, tx_line});
    txe = 1'b0;
    wait_cyc(2);
    check("tx data off", 16'h0, {15'h0, tx_line});
    maint = 1'b1;
    n = 0;
    repeat (40) begin
      b = tx_line;
      wait_cyc(1);
      if (tx_line !== b) n++;
    end
    check("maint edges", 16'h1, {15'h0, n >= 8 && n <= 11});
    maint = 1'b0;
    tx_edges = 0;
    tx_ticks = 0;
    txrun = 1'b1;
    wait_cyc(250);
    txrun = 1'b0;
    wait_cyc(20);
    check("tx ticks", tx_edges[15:0], tx_ticks[15:0]);
    check("tx clock level", {15'h0, ~txc_n}, {15'h0, txc});
    for (int k = 1; k >= 0; k--) begin
      rx_ticks = 0;
      rxv = k[0];
      frame = 1'b1;
      wait_cyc(30);
      frame = 1'b0;
      wait_cyc(10);
      check("rx bit", {15'h0, k[0]}, {15'h0, rx_bit});
      check("rx ticks", 16'h1, {15'h0, rx_ticks > 0});
    end
    summarize();
  end
endmodule // tb_top

bind modem_status_change_monitor modem_status_assertions #(.FLAG_ROUTE(FLAG_ROUTE),
  .RING_CYCLES(RING_CYCLES), .MAINT_CYCLES(MAINT_CYCLES)) chk (.*);
